// ---- wdt_pkg.sv ----
// Constants, register map and carrier types of the watchdog and address-trap block.
// Assumes clk is the fast clock and the slow clock arrives on a pin.
package wdt_pkg;
	localparam int APB_ADDR_W = 12;
	localparam logic [11:0] CTRL_ADDR = 12'h034;
	localparam logic [11:0] CMD_ADDR = 12'h038;
	localparam logic [11:0] STATUS_ADDR = 12'h03c;

	localparam int CTRL_RAM_TRAP_BIT = 5;
	localparam int CTRL_TRAP_ACTION_BIT = 4;
	localparam int CTRL_ENABLE_BIT = 3;
	localparam int CTRL_TIME_LSB = 1;
	localparam int CTRL_OVF_ACTION_BIT = 0;
	localparam logic [7:0] CTRL_RESET = 8'h39;

	localparam logic [7:0] CMD_CLEAR = 8'h4e;
	localparam logic [7:0] CMD_DISABLE = 8'hb1;
	localparam logic [7:0] CMD_RAM_COMMIT = 8'hd2;

	localparam logic [31:0] UNDEF_READ = 32'h0000_0000;

	localparam int STAT_RUNNING_BIT = 0;
	localparam int STAT_COUNT_LSB = 1;
	localparam int STAT_PIN_BIT = 3;
	localparam int STAT_RAM_TRAP_BIT = 4;
	localparam int STAT_OVF_ACTION_BIT = 5;
	localparam int STAT_RESET_BUSY_BIT = 6;

	localparam int FC_TAP_LOG2_DEFAULT = 23;
	localparam int FS_TAP_LOG2_DEFAULT = 15;

	localparam int CLK_PERIOD_NS = 20;
	localparam int RESET_FC_PERIODS = 24;
	localparam int RESET_TIME_NS = RESET_FC_PERIODS * CLK_PERIOD_NS;
	localparam int RESET_CYCLES = RESET_TIME_NS / CLK_PERIOD_NS;

	localparam logic [15:0] SFR_LO_DEFAULT = 16'h0000;
	localparam logic [15:0] SFR_HI_DEFAULT = 16'h003f;
	localparam logic [15:0] RAM_LO_DEFAULT = 16'h0040;
	localparam logic [15:0] RAM_HI_DEFAULT = 16'h083f;
	localparam logic [15:0] DBR_LO_DEFAULT = 16'h0f00;
	localparam logic [15:0] DBR_HI_DEFAULT = 16'h0fff;

	typedef struct packed {
		logic [11:0] paddr;
		logic pwrite;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic valid;
		logic [15:0] addr;
	} fetch_s;

	function automatic logic [31:0] low_mask(input logic [4:0] n);
		return (32'h0000_0001 << n) - 32'h0000_0001;
	endfunction : low_mask
endpackage : wdt_pkg

// ---- wdt_counter.sv ----
// Prescaling divider followed by a two-stage binary counter.
// Assumes fs_edge is a one-cycle pulse already synchronised to clk.
module wdt_counter import wdt_pkg::*; #(
	parameter int FC_TAP_LOG2 = FC_TAP_LOG2_DEFAULT,
	parameter int FS_TAP_LOG2 = FS_TAP_LOG2_DEFAULT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic fs_edge,
	input wire logic use_fs,
	input wire logic [1:0] time_sel,
	input wire logic pause,
	input wire logic clear_bin,
	input wire logic hold_clear,
	output logic overflow,
	output logic [1:0] bin_count
);
	localparam int DIV_W = FC_TAP_LOG2 > FS_TAP_LOG2 ? FC_TAP_LOG2 : FS_TAP_LOG2;

	generate
		if (FC_TAP_LOG2 < 7 || FC_TAP_LOG2 > 31 || FS_TAP_LOG2 < 7 || FS_TAP_LOG2 > 31) begin : g_chk
			$error("Divider tap widths must lie between 7 and 31");
		end
	endgenerate

	logic [DIV_W-1:0] div;
	logic div_step;
	logic [4:0] tap;
	logic tick;

	assign div_step = !pause && (use_fs ? fs_edge : 1'b1);
	// Code 00 takes the highest tap, each step down two binary stages
	assign tap = (use_fs ? 5'(FS_TAP_LOG2) : 5'(FC_TAP_LOG2)) - {2'b00, time_sel, 1'b0};
	assign tick = div_step && ((32'(div) & low_mask(tap)) == low_mask(tap));

	// Divider is never cleared by software
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			div <= '0;
		end else if (div_step) begin
			div <= div + 1'b1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bin_count <= 2'b00;
			overflow <= 1'b0;
		end else begin
			overflow <= 1'b0;
			if (hold_clear || clear_bin) begin
				bin_count <= 2'b00;
			end else if (tick) begin
				bin_count <= bin_count + 2'b01;
				overflow <= (bin_count == 2'b11);
			end
		end
	end
endmodule : wdt_counter

// ---- wdt_fetch_trap.sv ----
// Classifies instruction fetch addresses into trapping areas.
// Assumes the fetch strobe is synchronous to clk and lasts one cycle per fetch.
module wdt_fetch_trap import wdt_pkg::*; #(
	parameter logic [15:0] SFR_LO = SFR_LO_DEFAULT,
	parameter logic [15:0] SFR_HI = SFR_HI_DEFAULT,
	parameter logic [15:0] RAM_LO = RAM_LO_DEFAULT,
	parameter logic [15:0] RAM_HI = RAM_HI_DEFAULT,
	parameter logic [15:0] DBR_LO = DBR_LO_DEFAULT,
	parameter logic [15:0] DBR_HI = DBR_HI_DEFAULT
) (
	input wire fetch_s fetch,
	input wire logic ram_trap_active,
	output logic trap_hit
);
	function automatic logic in_area(input logic [15:0] a, input logic [15:0] lo,
		input logic [15:0] hi);
		return (a >= lo) && (a <= hi);
	endfunction : in_area

	logic hit_fixed;
	logic hit_ram;

	assign hit_fixed = in_area(fetch.addr, SFR_LO, SFR_HI) || in_area(fetch.addr, DBR_LO, DBR_HI);
	assign hit_ram = ram_trap_active && in_area(fetch.addr, RAM_LO, RAM_HI);
	assign trap_hit = fetch.valid && (hit_fixed || hit_ram);
endmodule : wdt_fetch_trap

// ---- wdt_trap_top.sv ----
// Watchdog timer and address trap with an APB register slave.
// Assumes clk is the fast clock, fs_pin is the asynchronous slow clock, rst is asynchronous.
// Operation
// - Enable bit is set out of reset so counting starts unaided.
// - Two-bit time select picks four periods, 00 longest, 11 shortest.
// - Clear code resets only the binary counter; software repeats within 3/4 period.
// - Disable code acts only while the enable bit is zero.
// - While disabled the binary counter is held cleared.
// - Once overflow action is written to interrupt it cannot return to reset.
// - Overflow with interrupt action raises the watchdog interrupt.
// - Watchdog interrupt is non-maskable.
// - Watchdog interrupt is raised even while another interrupt is in service.
// - Overflow with reset action pulls reset pin low for at most 24 fast clocks.
// - Control register is write-only; reads return undefined data.
// - New RAM trap select takes effect only after the commit code.
// - Fetches from special-function or data-buffer areas always trap.
// - Fetches from internal RAM trap only while the committed RAM trap select is one.
// - Trap with interrupt action raises a non-maskable trap interrupt.
// - Trap interrupt is raised even while another interrupt is in service.
// - Trap with reset action pulls reset pin low for at most 24 fast clocks.
// - Counter pauses in stop, warm-up, idle and sleep, then resumes.
// - Built as prescaling divider and two-stage binary counter; overflow is the event.
module wdt_trap_top import wdt_pkg::*; #(
	parameter int FC_TAP_LOG2 = FC_TAP_LOG2_DEFAULT,
	parameter int FS_TAP_LOG2 = FS_TAP_LOG2_DEFAULT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire apb_req_s apb_req,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic fs_pin,
	input wire logic slow_mode,
	input wire logic divider_tap_select,
	input wire logic low_power_hold,
	input wire fetch_s fetch,
	output logic watchdog_irq,
	output logic address_trap_irq,
	output logic chip_reset_req,
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe
);
	typedef enum logic [1:0] {
		RST_IDLE = 2'b01,
		RST_PULSE = 2'b10
	} reset_state_e;

	function automatic logic [31:0] word_at(input logic [11:0] a);
		return {a[11:2], 2'b00};
	endfunction : word_at

	// Control fields
	logic watchdog_enable_bit;
	logic [1:0] detection_time_select;
	logic overflow_action_select;
	logic trap_action_select;
	logic ram_trap_select;
	logic ram_trap_active;
	logic running;

	// Bus decode
	logic setup_phase;
	logic write_take;
	logic hit_ctrl;
	logic hit_cmd;
	logic hit_status;
	logic ctrl_wr;
	logic cmd_wr;
	logic [7:0] wbyte;
	logic cmd_clear;
	logic cmd_disable;
	logic cmd_commit;

	// Counter and trap
	logic overflow;
	logic [1:0] bin_count;
	logic trap_hit;

	// Slow clock and pin sync
	logic [2:0] fs_sync;
	logic fs_level;
	logic fs_edge;
	logic [2:0] pin_sync;
	logic pin_level;

	// Reset pulse
	reset_state_e rst_state;
	logic [4:0] rst_count;
	logic reset_trigger;

	assign setup_phase = psel && !penable;
	assign write_take = psel && penable && apb_req.pwrite;
	assign hit_ctrl = word_at(apb_req.paddr) == 32'(CTRL_ADDR);
	assign hit_cmd = word_at(apb_req.paddr) == 32'(CMD_ADDR);
	assign hit_status = word_at(apb_req.paddr) == 32'(STATUS_ADDR);
	assign ctrl_wr = write_take && hit_ctrl;
	assign cmd_wr = write_take && hit_cmd;
	assign wbyte = apb_req.pwdata[7:0];
	assign cmd_clear = cmd_wr && (wbyte == CMD_CLEAR);
	assign cmd_disable = cmd_wr && (wbyte == CMD_DISABLE);
	assign cmd_commit = cmd_wr && (wbyte == CMD_RAM_COMMIT);

	assign pready = 1'b1;

	// Read data is captured in the setup cycle so it is stable for the access phase
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else if (setup_phase) begin
			pslverr <= !(hit_ctrl || hit_cmd || hit_status);
			if (hit_status && !apb_req.pwrite) begin
				prdata <= 32'h0000_0000;
				prdata[STAT_RUNNING_BIT] <= running;
				prdata[STAT_COUNT_LSB +: 2] <= bin_count;
				prdata[STAT_PIN_BIT] <= pin_level;
				prdata[STAT_RAM_TRAP_BIT] <= ram_trap_active;
				prdata[STAT_OVF_ACTION_BIT] <= overflow_action_select;
				prdata[STAT_RESET_BUSY_BIT] <= (rst_state == RST_PULSE);
			end else begin
				prdata <= UNDEF_READ;
			end
		end
	end

	// Control register fields
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			watchdog_enable_bit <= CTRL_RESET[CTRL_ENABLE_BIT];
			detection_time_select <= CTRL_RESET[CTRL_TIME_LSB +: 2];
			trap_action_select <= CTRL_RESET[CTRL_TRAP_ACTION_BIT];
			ram_trap_select <= CTRL_RESET[CTRL_RAM_TRAP_BIT];
		end else if (ctrl_wr) begin
			watchdog_enable_bit <= wbyte[CTRL_ENABLE_BIT];
			detection_time_select <= wbyte[CTRL_TIME_LSB +: 2];
			trap_action_select <= wbyte[CTRL_TRAP_ACTION_BIT];
			ram_trap_select <= wbyte[CTRL_RAM_TRAP_BIT];
		end
	end

	// Overflow action can only move from reset to interrupt
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			overflow_action_select <= CTRL_RESET[CTRL_OVF_ACTION_BIT];
		end else if (ctrl_wr && !wbyte[CTRL_OVF_ACTION_BIT]) begin
			overflow_action_select <= 1'b0;
		end
	end

	// RAM trap select takes effect on the commit code
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ram_trap_active <= CTRL_RESET[CTRL_RAM_TRAP_BIT];
		end else if (cmd_commit) begin
			ram_trap_active <= ram_trap_select;
		end
	end

	// Run state: disable code is honoured only with the enable bit low
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			running <= 1'b1;
		end else if (ctrl_wr && wbyte[CTRL_ENABLE_BIT]) begin
			running <= 1'b1;
		end else if (cmd_disable && !watchdog_enable_bit) begin
			running <= 1'b0;
		end
	end

	// Slow clock pin: a rising change counts once the second and third stages agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fs_sync <= 3'b000;
			fs_level <= 1'b0;
			fs_edge <= 1'b0;
		end else begin
			fs_sync <= {fs_sync[1:0], fs_pin};
			fs_edge <= 1'b0;
			if (fs_sync[1] == fs_sync[2] && fs_sync[2] != fs_level) begin
				fs_level <= fs_sync[2];
				fs_edge <= fs_sync[2];
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pin_sync <= 3'b111;
			pin_level <= 1'b1;
		end else begin
			pin_sync <= {pin_sync[1:0], reset_pin_in};
			if (pin_sync[1] == pin_sync[2]) begin
				pin_level <= pin_sync[2];
			end
		end
	end

	wdt_counter #(
		.FC_TAP_LOG2(FC_TAP_LOG2),
		.FS_TAP_LOG2(FS_TAP_LOG2)
	) u_counter (
		.clk(clk),
		.rst(rst),
		.fs_edge(fs_edge),
		.use_fs(slow_mode || divider_tap_select),
		.time_sel(detection_time_select),
		.pause(low_power_hold),
		.clear_bin(cmd_clear),
		.hold_clear(!running),
		.overflow(overflow),
		.bin_count(bin_count)
	);

	wdt_fetch_trap u_trap (
		.fetch(fetch),
		.ram_trap_active(ram_trap_active),
		.trap_hit(trap_hit)
	);

	// Interrupts are non-maskable and never wait for a service in progress
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			watchdog_irq <= 1'b0;
			address_trap_irq <= 1'b0;
		end else begin
			watchdog_irq <= overflow && !overflow_action_select;
			address_trap_irq <= trap_hit && !trap_action_select;
		end
	end

	assign reset_trigger = (overflow && overflow_action_select) || (trap_hit && trap_action_select);

	// Reset pulse of a fixed number of fast clocks
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rst_state <= RST_IDLE;
			rst_count <= 5'd0;
		end else begin
			case (rst_state)
				RST_IDLE: begin
					if (reset_trigger) begin
						rst_state <= RST_PULSE;
						rst_count <= 5'(RESET_CYCLES - 1);
					end
				end
				RST_PULSE: begin
					if (rst_count == 5'd0) begin
						rst_state <= RST_IDLE;
					end else begin
						rst_count <= rst_count - 5'd1;
					end
				end
				default: begin
					rst_state <= RST_IDLE;
					rst_count <= 5'd0;
				end
			endcase
		end
	end

	assign reset_pin_out = 1'b0;
	assign reset_pin_oe = (rst_state == RST_PULSE);
	assign chip_reset_req = (rst_state == RST_PULSE);

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	enable_reset_a: assert property ($past(rst) |-> watchdog_enable_bit && running)
		else $error("Watchdog not running after reset release");

	clear_count_a: assert property (cmd_clear |=> bin_count == 2'b00)
		else $error("Clear code did not zero the binary counter");

	disable_ignored_a: assert property (cmd_disable && watchdog_enable_bit && running |=> running)
		else $error("Disable code acted with enable bit set");

	disabled_hold_a: assert property (!running ##1 !running |-> bin_count == 2'b00)
		else $error("Counter moved while disabled");

	action_lock_a: assert property (!overflow_action_select |=> !overflow_action_select)
		else $error("Overflow action returned to reset");

	wdt_irq_a: assert property (overflow && !overflow_action_select |=> watchdog_irq)
		else $error("Overflow did not raise watchdog interrupt");

	reset_len_a: assert property ($rose(reset_pin_oe) |-> ##23 reset_pin_oe ##1 !reset_pin_oe)
		else $error("Reset pulse length wrong");

	wdt_reset_a: assert property (overflow && overflow_action_select |=> reset_pin_oe && chip_reset_req)
		else $error("Overflow did not drive reset");

	ram_commit_a: assert property (!cmd_commit |=> $stable(ram_trap_active))
		else $error("RAM trap select changed without commit");

	trap_irq_a: assert property (trap_hit && !trap_action_select |=> address_trap_irq)
		else $error("Fetch trap did not raise interrupt");

	trap_reset_a: assert property (trap_hit && trap_action_select |=> reset_pin_oe)
		else $error("Fetch trap did not drive reset");

	pause_hold_a: assert property (low_power_hold && !cmd_clear && running |=> $stable(bin_count))
		else $error("Counter moved while paused");

	other_code_a: assert property (cmd_wr && !cmd_clear && !cmd_disable && !cmd_commit
		|=> $stable(running) && $stable(ram_trap_active))
		else $error("Unknown command code changed state");

	disable_taken_a: assert property (cmd_disable && !watchdog_enable_bit |=> !running)
		else $error("Disable code ignored with enable bit clear");

	commit_copy_a: assert property (cmd_commit
		|=> ram_trap_active == $past(ram_trap_select))
		else $error("Commit code did not take the RAM trap select");

	// Each event reaches exactly one of its two outcomes
	reset_no_irq_a: assert property (overflow && overflow_action_select
		|=> !watchdog_irq)
		else $error("Overflow with reset action raised an interrupt");

	trap_no_irq_a: assert property (trap_hit && trap_action_select
		|=> !address_trap_irq)
		else $error("Fetch trap with reset action raised an interrupt");

	ram_gate_a: assert property (fetch.valid && !ram_trap_active && !trap_action_select
		&& fetch.addr >= RAM_LO_DEFAULT && fetch.addr <= RAM_HI_DEFAULT |=> !address_trap_irq)
		else $error("RAM fetch trapped while RAM trap inactive");

	fixed_area_a: assert property (fetch.valid && !trap_action_select
		&& fetch.addr <= SFR_HI_DEFAULT |=> address_trap_irq)
		else $error("Special-function fetch did not trap");

	ovf_from_three_a: assert property (overflow |-> $past(bin_count) == 2'b11)
		else $error("Overflow without a full binary counter");

	irq_single_a: assert property (watchdog_irq |=> !watchdog_irq)
		else $error("Watchdog interrupt longer than one cycle");
endmodule : wdt_trap_top

// ---- cpu_model.sv ----
// Instruction fetch model of the CPU core facing the address trap logic.
// Assumes the trap answer arrives in the cycle after the fetch cycle.
module cpu_model import wdt_pkg::*; (
	input wire logic clk,
	input wire logic trap_irq,
	output fetch_s fetch
);
	timeunit 1ns;
	timeprecision 1ns;

	initial fetch = '{1'b0, 16'hffff};

	// Released address is inverted so a stale value never looks like a fetch
	task automatic fetch_one(input logic [15:0] a, output logic hit);
		@(posedge clk);
		fetch <= '{1'b1, a};
		@(posedge clk);
		fetch <= '{1'b0, ~a};
		#1;
		hit = trap_irq;
		@(posedge clk);
	endtask : fetch_one
endmodule : cpu_model

// ---- test_watchdog_and_address_trap.sv ----
// Self-checking bench of the watchdog and address trap block over APB.
// Assumes shortened divider taps of 7 and a pull-up on the reset pin.
module test_watchdog_and_address_trap import wdt_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;

	logic clk, rst, psel, penable, fs_pin, low_power_hold;
	apb_req_s apb_req;
	fetch_s fetch;
	logic [31:0] prdata, r;
	logic pready, pslverr, e, h;
	logic slow, tap_sel;
	logic watchdog_irq, address_trap_irq, chip_reset_req, reset_pin_out, reset_pin_oe;
	int bad_count, comparisons, wirq, cyc, last, gap, k, ln;

	wdt_trap_top #(.FC_TAP_LOG2(7), .FS_TAP_LOG2(7)) DUT (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .apb_req(apb_req), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fs_pin(fs_pin), .slow_mode(slow), .divider_tap_select(tap_sel),
		.low_power_hold(low_power_hold), .fetch(fetch), .watchdog_irq(watchdog_irq),
		.address_trap_irq(address_trap_irq), .chip_reset_req(chip_reset_req),
		.reset_pin_in(~reset_pin_oe), .reset_pin_out(reset_pin_out),
		.reset_pin_oe(reset_pin_oe));
	cpu_model cpu (.clk(clk), .trap_irq(address_trap_irq), .fetch(fetch));

	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	initial begin
		fs_pin = 0;
		forever #300 fs_pin = ~fs_pin;
	end

	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (watchdog_irq === 1'b1) begin
			gap <= cyc - last;
			last <= cyc;
			wirq <= wirq + 1;
		end
	end

	task automatic close_out;
		$display("comparisons %0d bad_count %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", nm, x, s);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		apb_req <= '{a, w, d};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr

	task automatic rd(input logic [11:0] a);
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	function automatic logic [31:0] ctl(input logic ra, ta, en, input logic [1:0] t, input logic ov);
		return {26'h0, ra, ta, en, t, ov};
	endfunction : ctl

	task automatic cycles(input int c);
		repeat (c) @(posedge clk);
	endtask : cycles

	// Waits for the reset pin to be pulled, then counts the cycles it stays pulled
	task automatic pulse_len(output int w);
		int n;
		n = 0;
		w = 0;
		while (reset_pin_oe !== 1'b1 && n < 1000) begin
			@(posedge clk);
			#1;
			n++;
		end
		while (reset_pin_oe === 1'b1 && w < 100) begin
			chk("chip_reset", chip_reset_req, 1);
			@(posedge clk);
			#1;
			w++;
		end
	endtask : pulse_len

	task automatic wait_irq(input int c);
		int n, t;
		n = 0;
		t = wirq + c;
		while (wirq < t && n < 5000) begin
			@(posedge clk);
			n++;
		end
		chk("irq_wait", n < 5000, 1);
	endtask : wait_irq

	initial begin
		rst = 1;
		psel = 0;
		penable = 0;
		apb_req = '0;
		low_power_hold = 0;
		slow = 0;
		tap_sel = 0;
		cycles(5);
		rst <= 0;
		rd(STATUS_ADDR);
		chk("running", r[0], 1);
		chk("ovf_action", r[5], 1);
		chk("status_reset", r, 32'h0000_0039);
		rd(CTRL_ADDR);
		chk("ctrl_read", r, UNDEF_READ);
		rd(12'h040);
		chk("unmapped_err", e, 1);
		pulse_len(ln);
		chk("wdt_reset_len", ln, RESET_CYCLES);
		chk("pin_out", reset_pin_out, 0);
		wr(CTRL_ADDR, ctl(1, 0, 1, 0, 0));
		wr(CTRL_ADDR, ctl(1, 0, 1, 0, 1));
		rd(STATUS_ADDR);
		chk("ovf_locked", r[5], 0);
		for (int t = 3; t >= 0; t--) begin
			wr(CTRL_ADDR, ctl(1, 0, 1, t[1:0], 0));
			wait_irq(3);
			chk("period", gap, 4 << (7 - 2 * t));
		end
		// Slow clock steps the divider once per 30 fast cycles
		wr(CTRL_ADDR, ctl(1, 0, 1, 3, 0));
		slow <= 1'b1;
		wait_irq(3);
		chk("slow_period", gap, 30 * 8);
		slow <= 1'b0;
		tap_sel <= 1'b1;
		wait_irq(3);
		chk("tap_period", gap, 30 * 8);
		wr(CMD_ADDR, CMD_CLEAR);
		tap_sel <= 1'b0;
		wr(CTRL_ADDR, ctl(1, 0, 1, 0, 0));
		k = wirq;
		repeat (6) begin
			wr(CTRL_ADDR + 12'h004, CMD_CLEAR);
			cycles(300);
		end
		chk("cleared_no_irq", wirq, k);
		k = wirq;
		repeat (3) begin
			wr(CMD_ADDR, 32'h0000_004f);
			cycles(300);
		end
		chk("junk_ignored", wirq != k, 1);
		wr(CMD_ADDR, CMD_CLEAR);
		low_power_hold <= 1'b1;
		k = wirq;
		cycles(1200);
		chk("hold_paused", wirq, k);
		low_power_hold <= 1'b0;
		wr(CMD_ADDR, CMD_CLEAR);
		wait_irq(1);
		chk("resumed", wirq, k + 1);
		wr(CMD_ADDR, CMD_DISABLE);
		rd(STATUS_ADDR);
		chk("disable_ignored", r[0], 1);
		wr(CMD_ADDR, CMD_CLEAR);
		wr(CTRL_ADDR, ctl(1, 0, 0, 0, 0));
		wr(CMD_ADDR, CMD_DISABLE);
		rd(STATUS_ADDR);
		chk("stopped", r[0], 0);
		chk("count_clear", r[2:1], 0);
		k = wirq;
		cycles(1100);
		chk("no_irq_off", wirq, k);
		cpu.fetch_one(16'h0010, h);
		chk("sfr_trap", h, 1);
		cpu.fetch_one(16'h0f80, h);
		chk("dbr_trap", h, 1);
		cpu.fetch_one(16'h0100, h);
		chk("ram_trap", h, 1);
		cpu.fetch_one(16'h1000, h);
		chk("rom_no_trap", h, 0);
		wr(CTRL_ADDR, ctl(0, 0, 0, 0, 0));
		cpu.fetch_one(16'h0100, h);
		chk("ram_uncommitted", h, 1);
		wr(CMD_ADDR, CMD_RAM_COMMIT);
		cpu.fetch_one(16'h0100, h);
		chk("ram_committed", h, 0);
		cpu.fetch_one(16'h003f, h);
		chk("sfr_still", h, 1);
		cpu.fetch_one(16'h0f00, h);
		chk("dbr_still", h, 1);
		wr(CTRL_ADDR, ctl(0, 1, 0, 0, 0));
		fork
			pulse_len(ln);
			cpu.fetch_one(16'h0020, h);
			begin
				cycles(6);
				rd(STATUS_ADDR);
			end
		join
		chk("trap_no_irq", h, 0);
		chk("trap_reset_len", ln, RESET_CYCLES);
		chk("reset_busy", r[6], 1);
		chk("pin_seen_low", r[3], 0);
		close_out();
	end

	initial begin
		#600_000;
		bad_count++;
		close_out();
	end
endmodule : test_watchdog_and_address_trap
